// ### rtl/hc_frame_pkg.sv
// package: register map, field layout, reset values and carrier types for the irq mask / frame block
// Operation
// R1 - writing one to a mask-clear bit clears that interrupt enable bit
// R2 - writing zero to a mask-clear bit leaves that enable bit unchanged
// R3 - reading mask-clear returns the live interrupt enable mask
// R4 - mask-clear is read with code 05h, written with code 85h
// R5 - one at bit 31 of mask-clear turns off all interrupts; zero ignored
// R6 - hardware or soft reset leaves the master gate disabled
// R7 - bits 6, 5, 4 gate root port change, frame wrap, fatal fault
// R8 - bits 3, 2, 0 gate resume, frame begin, overrun; rest reserved
// R9 - frame interval is read with code 0Dh, written with code 8Dh
// R10 - bits 13..0 hold the 14-bit frame length in bit times
// R11 - frame length resets to 11999
// R12 - controller soft reset returns frame length to 11999
// R13 - each frame start loads the 15-bit packet budget into its counter
// R14 - software computes the packet budget; hardware never derives it
// R15 - software inverts the interval toggle whenever it writes frame length
// R16 - software may trim frame length at each frame start
// R17 - software saves frame length before soft reset, may restore it
// R18 - interrupt only when flag, its enable bit and master gate are set
// R19 - time-left counter at zero reloads from frame length next bit time
// R20 - time-left counter at zero copies interval toggle into its toggle
// R21 - reserved bits read zero and ignore writes
package hc_frame_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MASK_CLEAR_RD = 8'h05;
  localparam logic [7:0] CMD_MASK_CLEAR_WR = 8'h85;
  localparam logic [7:0] CMD_MASK_SET_RD = 8'h04;
  localparam logic [7:0] CMD_MASK_SET_WR = 8'h84;
  localparam logic [7:0] CMD_FRAME_INTERVAL_RD = 8'h0D;
  localparam logic [7:0] CMD_FRAME_INTERVAL_WR = 8'h8D;
  localparam logic [7:0] CMD_TIME_LEFT_RD = 8'h0E;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int MASTER_GATE_BIT = 31;
  localparam int ROOT_PORT_CHANGE_BIT = 6;
  localparam int FRAME_COUNT_WRAP_BIT = 5;
  localparam int FATAL_SYSTEM_FAULT_BIT = 4;
  localparam int RESUME_SEEN_BIT = 3;
  localparam int FRAME_BEGIN_BIT = 2;
  localparam int SCHED_OVERRUN_BIT = 0;
  localparam logic [31:0] MASK_IMPL_BITS = 32'h8000007D;
  localparam int FRAME_LENGTH_LSB = 0;
  localparam int FRAME_LENGTH_W = 14;
  localparam int BUDGET_LSB = 16;
  localparam int BUDGET_W = 15;
  localparam int INTERVAL_TOGGLE_BIT = 31;
  localparam int TIME_LEFT_TOGGLE_BIT = 31;
  localparam int SOURCE_W = 7;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [13:0] FRAME_LENGTH_NOMINAL = 14'h2EDF;
  localparam logic [14:0] BUDGET_RESET = 15'h0000;
  localparam logic [13:0] TIME_LEFT_RESET = 14'h0000;
  // 12 Mbit/s bit time at the 125 MHz clock, rounded down to whole cycles
  localparam int SYS_CLK_MHZ = 125;
  localparam int BIT_RATE_MHZ = 12;
  localparam int BIT_TIME_CYCLES = SYS_CLK_MHZ / BIT_RATE_MHZ;
  localparam logic [3:0] BIT_TIME_LAST = 4'(BIT_TIME_CYCLES - 1);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [13:0] count;
    logic toggle;
    logic [3:0] bit_div;
    logic frame_start;
  } frame_timer_s;

endpackage : hc_frame_pkg

// ### rtl/hc_frame_timer.sv
// frame time-left down counter, reloaded from the frame length
module hc_frame_timer (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_soft_reset,
  input wire logic i_run,
  input wire logic [13:0] i_frame_length,
  input wire logic i_interval_toggle,
  output hc_frame_pkg::frame_timer_s o_state
);
  import hc_frame_pkg::*;

  frame_timer_s s_q;
  frame_timer_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.frame_start = 1'b0;
    if (i_soft_reset || !i_run) begin
      s_d.count = TIME_LEFT_RESET;
      s_d.toggle = 1'b0;
      s_d.bit_div = 4'h0;
    end else if (s_q.bit_div == BIT_TIME_LAST) begin
      s_d.bit_div = 4'h0;
      if (s_q.count == TIME_LEFT_RESET) begin
        s_d.count = i_frame_length; // [R19]
        s_d.toggle = i_interval_toggle; // [R20]
        s_d.frame_start = 1'b1;
      end else begin
        s_d.count = s_q.count - 14'h0001;
      end
    end else begin
      s_d.bit_div = s_q.bit_div + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_state = s_q;

  AST_RELOAD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R19]
    (i_run && !i_soft_reset && s_q.bit_div == BIT_TIME_LAST && s_q.count == 14'h0000)
    |=> (s_q.count == $past(i_frame_length) && s_q.frame_start))
    else $error("time-left counter not reloaded from frame length");

  AST_TOGGLE_COPY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R20]
    $rose(s_q.frame_start) |-> s_q.toggle == $past(i_interval_toggle))
    else $error("time-left toggle not copied from interval toggle");

endmodule : hc_frame_timer

// ### rtl/hc_irq_mask_and_frame_interval.sv
// interrupt enable mask with clear path, frame interval register and frame timer hookup
module hc_irq_mask_and_frame_interval (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_controller_soft_reset,
  input wire logic i_run,
  input wire logic [6:0] i_source_flags,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic o_frame_begin,
  output logic [14:0] o_packet_bit_budget_count,
  output logic [13:0] o_frame_time_left_count,
  output logic o_time_left_toggle
);
  import hc_frame_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] enable_mask;
    logic [13:0] frame_length;
    logic [14:0] budget;
    logic interval_toggle;
    logic [14:0] budget_count;
    logic [31:0] rdata;
    logic irq;
    logic frame_begin;
    logic [13:0] time_left;
    logic time_left_toggle;
  } state_s;

  state_s s_q;
  state_s s_d;
  frame_timer_s timer;
  reg_req_s req;
  logic [31:0] interval_word;
  logic [31:0] time_left_word;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  hc_frame_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_soft_reset(i_controller_soft_reset),
    .i_run(i_run),
    .i_frame_length(s_q.frame_length),
    .i_interval_toggle(s_q.interval_toggle),
    .o_state(timer)
  );

  // reserved bits are simply never stored, so they read zero [R21]
  always_comb begin
    interval_word = '0;
    interval_word[INTERVAL_TOGGLE_BIT] = s_q.interval_toggle;
    interval_word[BUDGET_LSB +: BUDGET_W] = s_q.budget;
    interval_word[FRAME_LENGTH_LSB +: FRAME_LENGTH_W] = s_q.frame_length; // [R10]
    time_left_word = '0;
    time_left_word[TIME_LEFT_TOGGLE_BIT] = timer.toggle;
    time_left_word[FRAME_LENGTH_LSB +: FRAME_LENGTH_W] = timer.count;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdata = '0;
    if (req.wr) begin
      case (req.addr)
        CMD_MASK_CLEAR_WR: begin
          // ones clear, zeros leave alone [R1] [R2] [R4] [R5]
          s_d.enable_mask = s_q.enable_mask & ~(req.wdata & MASK_IMPL_BITS);
        end
        CMD_MASK_SET_WR: begin
          s_d.enable_mask = s_q.enable_mask | (req.wdata & MASK_IMPL_BITS);
        end
        CMD_FRAME_INTERVAL_WR: begin
          s_d.interval_toggle = req.wdata[INTERVAL_TOGGLE_BIT];
          s_d.budget = req.wdata[BUDGET_LSB +: BUDGET_W]; // [R14]
          s_d.frame_length = req.wdata[FRAME_LENGTH_LSB +: FRAME_LENGTH_W]; // [R9] [R16]
        end
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        CMD_MASK_CLEAR_RD: s_d.rdata = s_q.enable_mask; // [R3] [R4]
        CMD_MASK_SET_RD: s_d.rdata = s_q.enable_mask;
        CMD_FRAME_INTERVAL_RD: s_d.rdata = interval_word; // [R9]
        CMD_TIME_LEFT_RD: s_d.rdata = time_left_word;
        default: s_d.rdata = '0;
      endcase
    end
    // soft reset wins over a same-cycle write to frame length or mask: the driver restores afterwards
    if (i_controller_soft_reset) begin
      s_d.frame_length = FRAME_LENGTH_NOMINAL; // [R12] [R17]
      s_d.enable_mask = MASK_RESET; // [R6]
    end
    if (timer.frame_start) begin
      s_d.budget_count = s_q.budget; // [R13]
    end
    // one gate per source bit, master gate over all [R7] [R8] [R18]
    s_d.irq = s_q.enable_mask[MASTER_GATE_BIT] &&
              |(i_source_flags & s_q.enable_mask[SOURCE_W-1:0]);
    s_d.frame_begin = timer.frame_start;
    s_d.time_left = timer.count;
    s_d.time_left_toggle = timer.toggle;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
      s_q.enable_mask <= MASK_RESET; // [R6]
      s_q.frame_length <= FRAME_LENGTH_NOMINAL; // [R11]
      s_q.budget <= BUDGET_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_irq = s_q.irq;
  assign o_frame_begin = s_q.frame_begin;
  assign o_packet_bit_budget_count = s_q.budget_count;
  assign o_frame_time_left_count = s_q.time_left;
  assign o_time_left_toggle = s_q.time_left_toggle;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CLEAR_ONES: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R1]
    (i_wr && i_addr == CMD_MASK_CLEAR_WR) |=> ((s_q.enable_mask & $past(i_wdata)) == 32'h0))
    else $error("written one did not clear enable bit");

  AST_CLEAR_ZEROS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R2]
    (i_wr && i_addr == CMD_MASK_CLEAR_WR && !i_controller_soft_reset)
    |=> ((s_q.enable_mask & ~$past(i_wdata)) == ($past(s_q.enable_mask) & ~$past(i_wdata))))
    else $error("written zero changed enable bit");

  AST_READ_MASK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R3]
    (i_rd && i_addr == CMD_MASK_CLEAR_RD) |=> o_rdata == $past(s_q.enable_mask))
    else $error("mask-clear read did not return enable mask");

  AST_MASTER_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R5]
    (i_wr && i_addr == CMD_MASK_CLEAR_WR && i_wdata[31]) |=> ##1 !o_irq)
    else $error("interrupt after master gate cleared");

  AST_SOFT_RESET: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R6]
    i_controller_soft_reset |=> (!s_q.enable_mask[MASTER_GATE_BIT] ##1 !o_irq))
    else $error("master gate not disabled by soft reset");

  AST_NOMINAL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R12]
    i_controller_soft_reset |=> s_q.frame_length == FRAME_LENGTH_NOMINAL)
    else $error("frame length not nominal after soft reset");

  AST_BUDGET_LOAD: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R13]
    timer.frame_start |=> o_packet_bit_budget_count == $past(s_q.budget))
    else $error("budget counter not loaded at frame start");

  AST_IRQ_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R18]
    o_irq |-> $past(s_q.enable_mask[31]) && ($past(i_source_flags & s_q.enable_mask[6:0]) != 7'h0))
    else $error("interrupt without flag, enable and master gate");

  AST_RESERVED: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R21]
    (s_q.enable_mask & ~MASK_IMPL_BITS) == 32'h0 && interval_word[15:14] == 2'h0)
    else $error("reserved bit holds a value");

endmodule : hc_irq_mask_and_frame_interval

// ### bench/host_driver_model.sv
// host driver model: command-code register bus master for the irq mask / frame block
module host_driver_model (
  input wire logic i_sys_clk,
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h00000000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // budget, toggle and trimmed length come ready-made from the caller
  task automatic wr(input logic [7:0] cmd, input logic [31:0] data);
    @(posedge i_sys_clk);
    o_addr <= cmd;
    o_wdata <= data;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    // released lines show the inverse so a stale value cannot pass for a live one
    o_addr <= ~cmd;
    o_wdata <= ~data;
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output logic [31:0] data);
    @(posedge i_sys_clk);
    o_addr <= cmd;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    o_addr <= ~cmd;
    #1;
    data = i_rdata;
  endtask : rd
endmodule : host_driver_model

// ### bench/hc_irq_mask_and_frame_interval_bench.sv
// self-checking bench for the irq mask clear path and frame interval register
module hc_irq_mask_and_frame_interval_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hc_frame_pkg::*;

  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wc;
    logic [31:0] wd;
    logic [7:0] rc;
    logic [31:0] ex;
  } row_s;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic soft_q = 1'b0;
  logic run_q = 1'b0;
  logic [6:0] flags_q = 7'h00;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic irq;
  logic frame_begin;
  logic [14:0] budget;
  logic [13:0] left;
  logic left_toggle;
  logic [31:0] v;
  logic [31:0] saved;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  int bits[6] = '{6, 5, 4, 3, 2, 0};
  row_s rows[7] = '{
    '{8'h84, 32'hFFFFFFFF, 8'h05, 32'h8000007D},
    '{8'h85, 32'h00000010, 8'h05, 32'h8000006D},
    '{8'h85, 32'h00000000, 8'h05, 32'h8000006D},
    '{8'h85, 32'h80000002, 8'h05, 32'h0000006D},
    '{8'h8D, 32'hFFFFFFFF, 8'h0D, 32'hFFFF3FFF},
    '{8'h55, 32'hFFFFFFFF, 8'h55, 32'h00000000},
    '{8'h85, 32'h0000006D, 8'h04, 32'h00000000}};

  always #4 i_sys_clk = ~i_sys_clk;

  hc_irq_mask_and_frame_interval dut_u (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_controller_soft_reset(soft_q), .i_run(run_q), .i_source_flags(flags_q),
    .o_rdata(rdata), .o_irq(irq), .o_frame_begin(frame_begin),
    .o_packet_bit_budget_count(budget), .o_frame_time_left_count(left),
    .o_time_left_toggle(left_toggle));

  host_driver_model host_u (
    .i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] ex);
    n_tests++;
    if (seen !== ex) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, ex);
    end
  endtask : check

  task automatic results();
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask : settle

  // bounded wait for the next frame start; n returns the cycles waited
  task automatic wait_begin(output int n);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end while (frame_begin !== 1'b1 && n < 4000);
    check(32'(frame_begin), 32'h00000001);
  endtask : wait_begin

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    host_u.rd(8'h05, v);
    check(v, 32'h00000000);
    host_u.rd(8'h0D, v);
    check(v, 32'h00002EDF);
    foreach (rows[i]) begin
      host_u.wr(rows[i].wc, rows[i].wd);
      host_u.rd(rows[i].rc, v);
      check(v, rows[i].ex);
    end
    // gate off first, then master on, then the source's own clear
    foreach (bits[i]) begin
      @(posedge i_sys_clk);
      flags_q <= 7'h01 << bits[i];
      host_u.wr(8'h84, 32'h00000001 << bits[i]);
      settle();
      check(32'(irq), 32'h00000000);
      host_u.wr(8'h84, 32'h80000000);
      settle();
      check(32'(irq), 32'h00000001);
      host_u.wr(8'h85, 32'h00000001 << bits[i]);
      settle();
      check(32'(irq), 32'h00000000);
      host_u.wr(8'h85, 32'h80000000);
    end
    host_u.wr(8'h8D, {1'b1, 15'h1234, 2'b00, 14'h0014});
    @(posedge i_sys_clk);
    run_q <= 1'b1;
    wait_begin(n);
    check(32'(budget), 32'h00001234);
    check(32'(left_toggle), 32'h00000001);
    check(32'(left), 32'h00000014);
    host_u.rd(8'h0E, v);
    check(v, 32'h80000014);
    host_u.wr(8'h8D, {1'b0, 15'h0ABC, 2'b00, 14'h001E});
    wait_begin(n);
    check(32'(left_toggle), 32'h00000000);
    check(32'(budget), 32'h00000ABC);
    check(32'(left), 32'h0000001E);
    wait_begin(n);
    check(32'(n), 32'((14'h001E + 1) * BIT_TIME_CYCLES));
    host_u.wr(8'h84, 32'h8000007D);
    host_u.rd(8'h0D, saved);
    @(posedge i_sys_clk);
    soft_q <= 1'b1;
    @(posedge i_sys_clk);
    soft_q <= 1'b0;
    host_u.rd(8'h0D, v);
    check(32'(v[13:0]), 32'h00002EDF);
    host_u.rd(8'h05, v);
    check(v, 32'h00000000);
    host_u.wr(8'h8D, saved);
    host_u.rd(8'h0D, v);
    check(v, saved);
    // hardware reset in mid-run with the gate open and a trimmed length
    host_u.wr(8'h84, 32'h8000007D);
    settle();
    check(32'(irq), 32'h00000001);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    #1;
    check(32'(irq), 32'h00000000);
    host_u.rd(8'h05, v);
    check(v, 32'h00000000);
    host_u.rd(8'h0D, v);
    check(v, 32'h00002EDF);
    results();
  end
endmodule : hc_irq_mask_and_frame_interval_bench
